// >>> gpdm_core.v
// Decided for this implementation: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
// Summary of operation
// RULE_01 - frame release loads stack pointer from base
// RULE_02 - then pops saved base into frame base
// RULE_03 - frame release has no operand fields
// RULE_04 - legacy mode: eight 32-bit general registers
// RULE_05 - six 16-bit segment registers
// RULE_06 - legacy 32-bit flags and instruction pointer
// RULE_07 - 64-bit mode: sixteen registers, extras need prefix
// RULE_08 - 64-bit mode widens flags and pointer (code widens only the pointer; flags keep 32 bus-visible bits in both modes)
// RULE_09 - plain move supports documented source/destination paths
// RULE_10 - no memory-memory or segment-segment move
// RULE_11 - conditional move tests flags by condition code
// RULE_12 - conditional move 16/32-bit into general register
// RULE_13 - false condition leaves destination unchanged
// RULE_14 - paired condition names share one encoding
// RULE_15 - feature query reports conditional move support
// RULE_16 - some instructions rejected in 64-bit mode
// RULE_17 - 64-bit operand width follows size and override
// RULE_18 - conditions decode as carry/zero/parity/sign/overflow tests
// RULE_19 - pop reads stack width, advances pointer
`include "gpdm_defs.vh"

module gpdm_core #(
  parameter CMOV_SUPPORTED = 1'b1
) (
  // clock and reset
  input  wire        mclk,
  input  wire        nrst,
  // avalon-mm slave
  input  wire [7:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output wire [31:0] avs_readdata,
  output wire        avs_waitrequest,
  // memory subsystem
  output reg  [63:0] mem_addr,
  output reg         mem_rd,
  output reg         mem_wr,
  output reg  [63:0] mem_wdata,
  output reg  [1:0]  mem_size,
  input  wire [63:0] mem_rdata,
  input  wire        mem_ack
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  localparam ST_IDLE = 2'd0;
  localparam ST_MEM  = 2'd1;
  localparam ST_DONE = 2'd2;

  reg  [63:0] gpr_q [0:15];
  reg  [15:0] seg_q [0:5];
  reg  [63:0] ctl_q [0:7];
  reg  [63:0] flags_q;
  reg  [63:0] ip_q;
  reg  [15:0] cmd_q;
  reg  [3:0]  sel_q;
  reg  [63:0] dat_q;
  reg  [63:0] rd_q;
  reg  [3:0]  stat_q;
  reg         mode64_q;
  reg  [1:0]  st_q;
  reg  [31:0] rdata_q;
  reg         rvalid_q;
  reg  [63:0] dbg_q [0:7];

  wire [3:0]  op    = cmd_q[3:0];
  wire [3:0]  path  = cmd_q[7:4];
  wire [3:0]  cc    = cmd_q[`GPDM_F_CC_LO+3:`GPDM_F_CC_LO];
  wire [1:0]  szsel = cmd_q[`GPDM_F_SIZE_LO+1:`GPDM_F_SIZE_LO];
  wire        register_extension_prefix   = cmd_q[`GPDM_F_REX];
  wire        inv64 = cmd_q[`GPDM_F_INV64];

  // ----------------------------------------
  // condition decode
  // ----------------------------------------
  wire f_cf = flags_q[`GPDM_B_CF];
  wire f_pf = flags_q[`GPDM_B_PF];
  wire f_zf = flags_q[`GPDM_B_ZF];
  wire f_sf = flags_q[`GPDM_B_SF];
  wire f_of = flags_q[`GPDM_B_OF];
  reg  cond;
  // one code per pair, so alternate names cannot differ; see RULE_14
  always @* begin
    case (cc[3:1]) // see RULE_18
      3'd0:    cond = f_of;
      3'd1:    cond = f_cf;
      3'd2:    cond = f_zf;
      3'd3:    cond = f_cf | f_zf;
      3'd4:    cond = f_sf;
      3'd5:    cond = f_pf;
      3'd6:    cond = f_sf ^ f_of;
      default: cond = (f_sf ^ f_of) | f_zf;
    endcase
    cond = cond ^ cc[0]; // odd codes negate; see RULE_11
  end

  // ----------------------------------------
  // operand width and register reach
  // ----------------------------------------
  reg [1:0] osz;
  always @* begin
    if (!mode64_q)
      osz = (szsel == `GPDM_SZ_16) ? `GPDM_SZ_16 : `GPDM_SZ_32;
    else if (szsel == `GPDM_SZ_64 && !register_extension_prefix)
      osz = `GPDM_SZ_32; // 64-bit promotion needs prefix; see RULE_07
    else if (szsel == `GPDM_SZ_DEF)
      osz = `GPDM_SZ_32; // default width; see RULE_17
    else
      osz = szsel;
  end
  // extra registers only with prefix in 64-bit mode; see RULE_07
  wire [3:0] gidx = (mode64_q && register_extension_prefix) ? sel_q : {1'b0, sel_q[2:0]};
  wire       seg_ok = sel_q[2:0] < 3'd6; // see RULE_05
  wire [63:0] wmask = (osz == `GPDM_SZ_16) ? 64'h000000000000FFFF :
                      (osz == `GPDM_SZ_32) ? 64'h00000000FFFFFFFF :
                      64'hFFFFFFFFFFFFFFFF;
  wire [63:0] gval = gpr_q[gidx] & wmask;
  wire [63:0] sp   = gpr_q[{1'b0, `GPDM_SP_IDX}];
  wire [63:0] bp   = gpr_q[{1'b0, `GPDM_BP_IDX}];
  wire [63:0] stw  = mode64_q ? 64'h0000000000000008 :
                     64'h0000000000000004; // see RULE_19
  wire [63:0] amsk = mode64_q ? 64'hFFFFFFFFFFFFFFFF :
                     64'h00000000FFFFFFFF;

  // illegal combinations
  wire bad_path = (path == `GPDM_P_M2M) || (path == `GPDM_P_S2S) ||
                  (path > `GPDM_P_S2S); // see RULE_10
  // any nonzero override counts as present; keeps the feature bit one wide
  wire cmov_en  = (CMOV_SUPPORTED != 0);
  wire bad_cmov = (op == `GPDM_OP_CMOV) &&
                  (!cmov_en || osz == `GPDM_SZ_64 ||
                   !(path == `GPDM_P_M2G || path == `GPDM_P_G2G));
  wire bad_seg  = (path == `GPDM_P_M2S || path == `GPDM_P_S2M ||
                   path == `GPDM_P_G2S || path == `GPDM_P_S2G) && !seg_ok;
  wire illegal  = (mode64_q && inv64) || // see RULE_16
                  (op == `GPDM_OP_MOV && (bad_path || bad_seg)) ||
                  bad_cmov; // see RULE_12
  wire uses_mem = (op == `GPDM_OP_LEAVE) ||
                  ((op == `GPDM_OP_MOV || op == `GPDM_OP_CMOV) &&
                   (path == `GPDM_P_M2G || path == `GPDM_P_M2S ||
                    path == `GPDM_P_G2M || path == `GPDM_P_S2M ||
                    path == `GPDM_P_I2M));
  wire mem_is_wr = (path == `GPDM_P_G2M) || (path == `GPDM_P_S2M) ||
                   (path == `GPDM_P_I2M);

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  wire go = avs_write && !avs_waitrequest &&
            avs_address == `GPDM_A_CMD && st_q == ST_IDLE;
  // writes stall while busy; reads take one extra cycle
  assign avs_waitrequest = (avs_read && !rvalid_q) ||
                           (avs_write && st_q != ST_IDLE);
  assign avs_readdata    = rdata_q;

  reg [31:0] rmux;
  always @* begin
    case (avs_address)
      `GPDM_A_CMD:   rmux = {16'h0000, cmd_q};
      `GPDM_A_STAT:  rmux = {28'h0000000, stat_q};
      `GPDM_A_GPSEL: rmux = {28'h0000000, sel_q};
      `GPDM_A_DATLO: rmux = rd_q[31:0];
      `GPDM_A_DATHI: rmux = rd_q[63:32];
      `GPDM_A_FLAGS: rmux = flags_q[31:0];
      `GPDM_A_FEAT:  rmux = {16'h0000, cmov_en, 15'h0000}; // see RULE_15
      `GPDM_A_MODE:  rmux = {31'h00000000, mode64_q};
      `GPDM_A_IP:    rmux = ip_q[31:0];
      default:       rmux = 32'h00000000;
    endcase
  end

  wire [31:0] bemask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                        {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire wr_ok = avs_write && st_q == ST_IDLE;

  // ----------------------------------------
  // execution
  // ----------------------------------------
  integer i;
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      for (i = 0; i < 16; i = i + 1) gpr_q[i] <= 64'h0;
      for (i = 0; i < 6; i = i + 1) seg_q[i] <= 16'h0000;
      for (i = 0; i < 8; i = i + 1) ctl_q[i] <= 64'h0;
      for (i = 0; i < 8; i = i + 1) dbg_q[i] <= 64'h0;
      flags_q  <= `GPDM_FLAGS_RST;
      ip_q     <= 64'h0;
      cmd_q    <= 16'h0000;
      sel_q    <= 4'h0;
      dat_q    <= 64'h0;
      rd_q     <= 64'h0;
      stat_q   <= 4'h0;
      mode64_q <= 1'b0;
      st_q     <= ST_IDLE;
      rdata_q  <= 32'h00000000;
      rvalid_q <= 1'b0;
      mem_addr <= 64'h0;
      mem_rd   <= 1'b0;
      mem_wr   <= 1'b0;
      mem_wdata <= 64'h0;
      mem_size <= 2'h0;
    end else begin
      rvalid_q <= avs_read && !rvalid_q;
      rdata_q  <= rmux;
      if (wr_ok) begin
        case (avs_address)
          `GPDM_A_CMD:   cmd_q <= avs_writedata[15:0];
          `GPDM_A_GPSEL: sel_q <= avs_writedata[3:0];
          `GPDM_A_DATLO:
            dat_q[31:0] <= (dat_q[31:0] & ~bemask) | (avs_writedata & bemask);
          `GPDM_A_DATHI:
            dat_q[63:32] <= (dat_q[63:32] & ~bemask) |
                            (avs_writedata & bemask);
          `GPDM_A_FLAGS:
            flags_q[31:0] <= (flags_q[31:0] & ~bemask) |
                             (avs_writedata & bemask); // see RULE_06
          `GPDM_A_MODE:  mode64_q <= avs_writedata[0];
          default: ;
        endcase
      end
      case (st_q)
        ST_IDLE: if (go) begin
          stat_q[`GPDM_S_BUSY] <= 1'b1;
          st_q <= ST_DONE;
        end
        ST_DONE: begin
          // first decision cycle after the command is latched
          stat_q[`GPDM_S_TAKEN] <= 1'b0;
          stat_q[`GPDM_S_ILLEGAL] <= illegal;
          if (illegal) begin
            st_q <= ST_IDLE;
            stat_q[`GPDM_S_BUSY] <= 1'b0;
          end else if (op == `GPDM_OP_LEAVE) begin
            // operands come only from base register; see RULE_03
            gpr_q[{1'b0, `GPDM_SP_IDX}] <= bp; // see RULE_01
            mem_addr <= bp & amsk;
            mem_rd   <= 1'b1;
            mem_size <= mode64_q ? `GPDM_SZ_64 : `GPDM_SZ_32;
            st_q     <= ST_MEM;
          end else if (op == `GPDM_OP_RDREG) begin
            rd_q <= gval;
            st_q <= ST_IDLE;
            stat_q[`GPDM_S_BUSY] <= 1'b0;
          end else if (op == `GPDM_OP_CMOV && !cond) begin
            // destination untouched, next command free; see RULE_13
            st_q <= ST_IDLE;
            stat_q[`GPDM_S_BUSY] <= 1'b0;
          end else if (uses_mem) begin
            stat_q[`GPDM_S_TAKEN] <= 1'b1;
            mem_addr  <= dat_q & amsk;
            mem_size  <= osz;
            mem_rd    <= !mem_is_wr;
            mem_wr    <= mem_is_wr;
            mem_wdata <= (path == `GPDM_P_S2M) ? {48'h0, seg_q[sel_q[2:0]]} :
                         (path == `GPDM_P_I2M) ? (dat_q & wmask) : gval;
            st_q <= ST_MEM;
          end else begin
            stat_q[`GPDM_S_TAKEN] <= 1'b1;
            case (path) // see RULE_09
              `GPDM_P_G2G, `GPDM_P_I2G, `GPDM_P_C2G, `GPDM_P_D2G,
              `GPDM_P_S2G:
                gpr_q[gidx] <= (gpr_q[gidx] & ~wmask) |
                  (((path == `GPDM_P_C2G) ? ctl_q[sel_q[2:0]] :
                    (path == `GPDM_P_D2G) ? dbg_q[sel_q[2:0]] :
                    (path == `GPDM_P_S2G) ? {48'h0, seg_q[sel_q[2:0]]} :
                    dat_q) & wmask);
              `GPDM_P_G2S: seg_q[sel_q[2:0]] <= dat_q[15:0];
              `GPDM_P_G2C: ctl_q[sel_q[2:0]] <= dat_q & amsk;
              `GPDM_P_G2D: dbg_q[sel_q[2:0]] <= dat_q & amsk;
              default: ;
            endcase
            st_q <= ST_IDLE;
            stat_q[`GPDM_S_BUSY] <= 1'b0;
            ip_q <= (ip_q + 64'h1) & amsk; // see RULE_08
          end
        end
        ST_MEM: if (mem_ack) begin
          mem_rd <= 1'b0;
          mem_wr <= 1'b0;
          st_q   <= ST_IDLE;
          stat_q[`GPDM_S_BUSY] <= 1'b0;
          ip_q   <= (ip_q + 64'h1) & amsk;
          if (op == `GPDM_OP_LEAVE) begin
            gpr_q[{1'b0, `GPDM_BP_IDX}] <= mem_rdata & amsk; // see RULE_02
            gpr_q[{1'b0, `GPDM_SP_IDX}] <= (sp + stw) & amsk; // see RULE_19
          end else if (path == `GPDM_P_M2S)
            seg_q[sel_q[2:0]] <= mem_rdata[15:0];
          else if (path == `GPDM_P_M2G)
            gpr_q[gidx] <= (gpr_q[gidx] & ~wmask) | (mem_rdata & wmask);
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

endmodule // gpdm_core

// >>> gpdm_core_props.sv
`timescale 1ns/1ps
`include "gpdm_defs.vh"
module gpdm_core_props #(
  parameter CMOV_SUPPORTED = 1'b1
) (
  // clock and reset
  input wire        mclk,
  input wire        nrst,
  // register bus
  input wire [7:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0]  avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  // memory side
  input wire [63:0] mem_addr,
  input wire        mem_rd,
  input wire        mem_wr,
  input wire [63:0] mem_wdata,
  input wire [1:0]  mem_size,
  input wire [63:0] mem_rdata,
  input wire        mem_ack
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  // ----------------------------------------
  // bus and memory relations
  // ----------------------------------------
  property p_rd_wait;
    $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
  property p_feat;
    avs_read && !avs_waitrequest && avs_address == `GPDM_A_FEAT
      |-> avs_readdata[`GPDM_FEAT_CMOV] == CMOV_SUPPORTED;
  endproperty
  a_feat: assert property (p_feat) else $error("feature bit wrong");
  property p_unmap;
    avs_read && !avs_waitrequest && avs_address > 8'h20 |-> avs_readdata == 0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped not zero");
  property p_excl;
    !(mem_rd && mem_wr);
  endproperty
  a_excl: assert property (p_excl) else $error("read and write");
  property p_rd_hold;
    mem_rd && !mem_ack |=> mem_rd && $stable(mem_addr);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read dropped");
  property p_wr_hold;
    mem_wr && !mem_ack |=> mem_wr && $stable(mem_wdata) && $stable(mem_addr);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write dropped");
  property p_rd_end;
    mem_rd && mem_ack |=> !mem_rd;
  endproperty
  a_rd_end: assert property (p_rd_end) else $error("read not ended");
  property p_wr_end;
    mem_wr && mem_ack |=> !mem_wr;
  endproperty
  a_wr_end: assert property (p_wr_end) else $error("write not ended");
endmodule // gpdm_core_props

bind gpdm_core gpdm_core_props #(.CMOV_SUPPORTED(CMOV_SUPPORTED)) u_props (
  .mclk(mclk), .nrst(nrst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
  .mem_wdata(mem_wdata), .mem_size(mem_size), .mem_rdata(mem_rdata),
  .mem_ack(mem_ack));

// >>> gpdm_defs.vh
`ifndef GPDM_DEFS_VH
`define GPDM_DEFS_VH
// ----------------------------------------
// register map (word byte addresses)
// ----------------------------------------
`define GPDM_A_CMD      8'h00
`define GPDM_A_STAT     8'h04
`define GPDM_A_GPSEL    8'h08
`define GPDM_A_DATLO    8'h0C
`define GPDM_A_DATHI    8'h10
`define GPDM_A_FLAGS    8'h14
`define GPDM_A_FEAT     8'h18
`define GPDM_A_MODE     8'h1C
`define GPDM_A_IP       8'h20
// ----------------------------------------
// command opcodes (cmd[3:0])
// ----------------------------------------
`define GPDM_OP_LEAVE   4'h1
`define GPDM_OP_MOV     4'h2
`define GPDM_OP_CMOV    4'h3
`define GPDM_OP_RDREG   4'h4
// move paths (cmd[7:4])
`define GPDM_P_M2G      4'h0
`define GPDM_P_M2S      4'h1
`define GPDM_P_G2M      4'h2
`define GPDM_P_S2M      4'h3
`define GPDM_P_G2G      4'h4
`define GPDM_P_G2S      4'h5
`define GPDM_P_S2G      4'h6
`define GPDM_P_G2C      4'h7
`define GPDM_P_C2G      4'h8
`define GPDM_P_G2D      4'h9
`define GPDM_P_D2G      4'hA
`define GPDM_P_I2G      4'hB
`define GPDM_P_I2M      4'hC
`define GPDM_P_M2M      4'hD
`define GPDM_P_S2S      4'hE
// cmd fields
`define GPDM_F_CC_LO    8
`define GPDM_F_SIZE_LO  12
`define GPDM_F_REX      14
`define GPDM_F_INV64    15
// size codes
`define GPDM_SZ_DEF     2'h0
`define GPDM_SZ_16      2'h1
`define GPDM_SZ_32      2'h2
`define GPDM_SZ_64      2'h3
// flag bit positions
`define GPDM_B_CF       0
`define GPDM_B_PF       2
`define GPDM_B_ZF       6
`define GPDM_B_SF       7
`define GPDM_B_OF       11
// status bits
`define GPDM_S_BUSY     0
`define GPDM_S_ILLEGAL  1
`define GPDM_S_TAKEN    2
`define GPDM_S_MEMERR   3
// feature bits
`define GPDM_FEAT_CMOV  15
// reset values and stack register indices
`define GPDM_FLAGS_RST  64'h0000000000000002
`define GPDM_SP_IDX     3'h4
`define GPDM_BP_IDX     3'h5
`endif

// >>> gpdm_mem_model.sv
`timescale 1ns/1ps
module gpdm_mem_model (
  // clock and reset
  input  wire        mclk,
  input  wire        nrst,
  // memory port
  input  wire [63:0] mem_addr,
  input  wire        mem_rd,
  input  wire        mem_wr,
  input  wire [63:0] mem_wdata,
  output logic [63:0] mem_rdata,
  output logic       mem_ack,
  // last store seen
  output logic [63:0] wr_addr,
  output logic [63:0] wr_data
);
  logic [1:0] cnt_q;
  logic       slow_q;
  // alternate prompt and slow answers; idle data churns to expose stale use
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 2'h0;
      slow_q <= 1'b0;
      mem_ack <= 1'b0;
      mem_rdata <= 64'h0;
      wr_addr <= 64'h0;
      wr_data <= 64'h0;
    end else begin
      mem_ack <= 1'b0;
      if ((mem_rd || mem_wr) && !mem_ack) begin
        if (cnt_q == (slow_q ? 2'h3 : 2'h0)) begin
          mem_ack <= 1'b1;
          cnt_q <= 2'h0;
          slow_q <= ~slow_q;
          if (mem_rd)
            mem_rdata <= {~mem_addr[31:0], mem_addr[31:0] ^ 32'h5A5A_0000};
          if (mem_wr) begin
            wr_addr <= mem_addr;
            wr_data <= mem_wdata;
          end
        end else
          cnt_q <= cnt_q + 2'h1;
      end else if (!mem_ack)
        mem_rdata <= ~mem_rdata;
    end
  end
endmodule // gpdm_mem_model

// >>> tb_top.sv
`timescale 1ns/1ps
`include "gpdm_defs.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest;
  wire  [63:0] mem_addr, mem_wdata, mem_rdata, wr_addr, wr_data;
  wire         mem_rd, mem_wr, mem_ack;
  wire  [1:0]  mem_size;
  int          err_total = 0;
  int          tests_run = 0;
  logic [31:0] rd_q;
  always #2.5 mclk = ~mclk;
  gpdm_core u_dut (.mclk(mclk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_size(mem_size),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  gpdm_mem_model u_mem (.mclk(mclk), .nrst(nrst), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .wr_addr(wr_addr),
    .wr_data(wr_data));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic wrap_up();
    if (err_total == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 500);
    rd_q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 500) begin
      err_total++;
      wrap_up();
    end
  endtask
  // leaves the final status word in rd_q
  task automatic cmd(input logic [15:0] c);
    int n = 0;
    bus(1'b1, `GPDM_A_CMD, {16'h0, c});
    do begin
      bus(1'b0, `GPDM_A_STAT, 32'h0);
      n++;
    end while (rd_q[`GPDM_S_BUSY] !== 1'b0 && n < 50);
    if (n >= 50) begin
      err_total++;
      wrap_up();
    end
  endtask
  task automatic set_gpr(input logic [31:0] i, input logic [31:0] v);
    bus(1'b1, `GPDM_A_GPSEL, i);
    bus(1'b1, `GPDM_A_DATLO, v);
    bus(1'b1, `GPDM_A_DATHI, 32'h0);
    cmd({8'h00, `GPDM_P_I2G, `GPDM_OP_MOV});
  endtask
  task automatic get_gpr(input logic [31:0] i);
    bus(1'b1, `GPDM_A_GPSEL, i);
    cmd({12'h000, `GPDM_OP_RDREG});
    bus(1'b0, `GPDM_A_DATLO, 32'h0);
  endtask
  function automatic logic cond(input logic [3:0] cc, input logic [31:0] f);
    logic r;
    case (cc[3:1])
      3'h0: r = f[11];
      3'h1: r = f[0];
      3'h2: r = f[6];
      3'h3: r = f[0] | f[6];
      3'h4: r = f[7];
      3'h5: r = f[2];
      3'h6: r = f[7] ^ f[11];
      default: r = (f[7] ^ f[11]) | f[6];
    endcase
    return r ^ cc[0];
  endfunction
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    bus(1'b0, `GPDM_A_FLAGS, 32'h0);
    `CHK(rd_q, 32'h0000_0002)
    bus(1'b0, `GPDM_A_FEAT, 32'h0);
    `CHK(rd_q[`GPDM_FEAT_CMOV], 1'b1)
    bus(1'b0, 8'h40, 32'h0);
    `CHK(rd_q, 32'h0)
  endtask
  task automatic t_gpr();
    for (int i = 0; i < 8; i++)
      set_gpr(i, 32'h1100_0000 + i * 32'h0101);
    for (int i = 0; i < 8; i++) begin
      get_gpr(i);
      `CHK(rd_q, 32'h1100_0000 + i * 32'h0101)
    end
  endtask
  task automatic t_refuse();
    cmd({8'h00, `GPDM_P_M2M, `GPDM_OP_MOV});
    `CHK(rd_q[`GPDM_S_ILLEGAL], 1'b1)
    cmd({8'h00, `GPDM_P_S2S, `GPDM_OP_MOV});
    `CHK(rd_q[`GPDM_S_ILLEGAL], 1'b1)
    for (int m = 0; m < 2; m++) begin
      bus(1'b1, `GPDM_A_MODE, m);
      cmd({8'h80, `GPDM_P_I2G, `GPDM_OP_MOV});
      `CHK(rd_q[`GPDM_S_ILLEGAL], m[0])
    end
    bus(1'b1, `GPDM_A_MODE, 32'h0);
  endtask
  task automatic t_leave(input logic m64);
    bus(1'b1, `GPDM_A_MODE, {31'h0, m64});
    set_gpr(5, 32'h0000_2000);
    set_gpr(4, 32'h0000_1F00);
    cmd({12'h000, `GPDM_OP_LEAVE});
    `CHK(mem_size, m64 ? `GPDM_SZ_64 : `GPDM_SZ_32)
    get_gpr(5);
    `CHK(rd_q, 32'h5A5A_2000)
    get_gpr(4);
    `CHK(rd_q, m64 ? 32'h0000_2008 : 32'h0000_2004)
  endtask
  task automatic t_cmov();
    logic [31:0] fl;
    logic        e;
    for (int k = 0; k < 3; k++)
      for (logic [4:0] cc = 0; cc < 16; cc++) begin
        fl = (k == 0) ? 32'h0000_0047 :
             (k == 1) ? 32'h0000_0082 : 32'h0000_0842;
        set_gpr(1, 32'h0BAD_0001);
        bus(1'b1, `GPDM_A_FLAGS, fl);
        bus(1'b1, `GPDM_A_DATLO, 32'h3000);
        cmd({2'b00, `GPDM_SZ_32, cc[3:0], `GPDM_P_M2G, `GPDM_OP_CMOV});
        e = cond(cc[3:0], fl);
        `CHK(rd_q[`GPDM_S_TAKEN], e)
        get_gpr(1);
        `CHK(rd_q, e ? 32'h5A5A_3000 : 32'h0BAD_0001)
      end
  endtask
  task automatic t_store();
    set_gpr(2, 32'hCAFE_0002);
    bus(1'b1, `GPDM_A_DATLO, 32'h4000);
    cmd({8'h00, `GPDM_P_G2M, `GPDM_OP_MOV});
    `CHK(wr_addr[31:0], 32'h0000_4000)
    `CHK(wr_data[31:0], 32'hCAFE_0002)
    cmd({8'h00, `GPDM_P_M2G, `GPDM_OP_MOV});
    get_gpr(2);
    `CHK(rd_q, 32'h5A5A_4000)
  endtask
  task automatic t_seg();
    logic [31:0] ip0;
    bus(1'b0, `GPDM_A_IP, 32'h0);
    ip0 = rd_q;
    bus(1'b1, `GPDM_A_GPSEL, 32'h3);
    bus(1'b1, `GPDM_A_DATLO, 32'h0000_BEEF);
    cmd({8'h00, `GPDM_P_G2S, `GPDM_OP_MOV});
    cmd({8'h00, `GPDM_P_S2G, `GPDM_OP_MOV});
    bus(1'b0, `GPDM_A_IP, 32'h0);
    `CHK(rd_q, ip0 + 32'h2)
    get_gpr(3);
    `CHK(rd_q, 32'h0000_BEEF)
    bus(1'b1, `GPDM_A_GPSEL, 32'h6);
    cmd({8'h00, `GPDM_P_G2S, `GPDM_OP_MOV});
    `CHK(rd_q[`GPDM_S_ILLEGAL], 1'b1)
  endtask
  task automatic t_wide();
    bus(1'b1, `GPDM_A_MODE, 32'h1);
    set_gpr(1, 32'h0000_0001);
    bus(1'b1, `GPDM_A_GPSEL, 32'h9);
    bus(1'b1, `GPDM_A_DATLO, 32'h1111_0009);
    bus(1'b1, `GPDM_A_DATHI, 32'hAAAA_0009);
    cmd({2'b01, `GPDM_SZ_64, 4'h0, `GPDM_P_I2G, `GPDM_OP_MOV});
    cmd({2'b01, `GPDM_SZ_64, 8'h00, `GPDM_OP_RDREG});
    bus(1'b0, `GPDM_A_DATHI, 32'h0);
    `CHK(rd_q, 32'hAAAA_0009)
    bus(1'b0, `GPDM_A_DATLO, 32'h0);
    `CHK(rd_q, 32'h1111_0009)
    cmd({2'b00, `GPDM_SZ_64, 8'h00, `GPDM_OP_RDREG});
    bus(1'b0, `GPDM_A_DATLO, 32'h0);
    `CHK(rd_q, 32'h0000_0001)
    bus(1'b0, `GPDM_A_DATHI, 32'h0);
    `CHK(rd_q, 32'h0000_0000)
    bus(1'b1, `GPDM_A_MODE, 32'h0);
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    t_reset();
    t_gpr();
    t_refuse();
    t_leave(1'b1);
    t_leave(1'b0);
    t_cmov();
    t_store();
    t_seg();
    t_wide();
    wrap_up();
  end
endmodule // tb_top
